// ===== src/sts_pkg.sv
// Purpose: shared constants and carrier types for the supply and thermal supervisor
// Assumes: 100 MHz clock, byte-addressed classic Wishbone registers
// Notes: offsets are byte addresses of aligned 32-bit words
package sts_pkg;
  localparam int STS_CLK_MHZ = 100;
  // timing figures in microseconds and their cycle counts
  localparam int STS_T_RD1_US = 2000;
  localparam int STS_T_SC_US = 4000;
  localparam int STS_RD1_CYC = STS_T_RD1_US * STS_CLK_MHZ;
  localparam int STS_SC_CYC = STS_T_SC_US * STS_CLK_MHZ;
  localparam int STS_CNT_W = 20;
  localparam logic [2:0] STS_UV_LIMIT = 3'h4;
  // register offsets
  localparam logic [7:0] STS_MODE_OFF = 8'h00;
  localparam logic [7:0] STS_WAKE_CTRL_OFF = 8'h04;
  localparam logic [7:0] STS_WATCHDOG_CONTROL_REG_OFF = 8'h08;
  localparam logic [7:0] STS_STATUS_OFF = 8'h0c;
  localparam logic [7:0] STS_FAIL_OFF = 8'h10;
  localparam logic [7:0] STS_OUT_CTRL_OFF = 8'h14;
  // mode command codes
  localparam logic [1:0] STS_CMD_NORMAL = 2'h0;
  localparam logic [1:0] STS_CMD_STOP = 2'h1;
  localparam logic [1:0] STS_CMD_SLEEP = 2'h2;
  localparam logic [1:0] STS_CMD_SOFT_RST = 2'h3;
  // wake_control_reg fields
  localparam int STS_ARM_A_BIT = 0;
  localparam int STS_BUS_WAKE_BIT = 1;
  localparam int STS_KEEP_ON_BIT = 2;
  localparam logic [2:0] STS_WAKE_CTRL_RST = 3'h2;
  // watchdog_control_reg fields
  localparam int STS_ARM_B_BIT = 0;
  localparam int STS_OV_RST_BIT = 1;
  localparam logic [1:0] STS_WATCHDOG_CONTROL_REG_RST = 2'h0;
  // out control fields: [1:0] second regulator, [5:2] high-side switches
  localparam logic [5:0] STS_OUT_CTRL_RST = 6'h00;
  // status flag positions
  localparam int STS_F_POR = 0;
  localparam int STS_F_BAT_UV = 1;
  localparam int STS_F_HS_UV = 2;
  localparam int STS_F_HS_OV = 3;
  localparam int STS_F_PREWARN = 4;
  localparam int STS_F_MAIN_UV = 5;
  localparam int STS_F_REP_UV = 6;
  localparam int STS_F_MAIN_OV = 7;
  localparam int STS_F_SHORT = 8;
  localparam int STS_F_SEC_UV = 9;
  localparam int STS_F_CAN_UV = 10;
  localparam int STS_F_BLOCK_OT = 11;
  localparam int STS_F_SEC_OT = 12;
  localparam int STS_NFLAGS = 13;
  localparam logic [12:0] STS_STATUS_RST = 13'h0001;
  localparam logic [1:0] STS_FAIL_OT = 2'h1;

  typedef enum logic [2:0] {
    mode_init = 3'b000,
    mode_normal = 3'b001,
    mode_stop = 3'b010,
    mode_sleep = 3'b011,
    mode_restart = 3'b100,
    mode_failsafe = 3'b101,
    mode_off = 3'b110
  } sts_mode_t;

  // comparator levels, synchronous to clk
  typedef struct packed {
    logic bat_above_por;
    logic bat_uv;
    logic hs_uv;
    logic hs_ov;
    logic main_above_rt;
    logic main_prewarn;
    logic main_ov;
    logic second_uv;
    logic second_ramping;
    logic can_uv;
  } sts_supply_t;

  // per-stage overtemperature levels
  typedef struct packed {
    logic second_reg;
    logic can;
    logic lin1;
    logic lin2;
    logic hs;
  } sts_heat_t;
endpackage

// ===== src/sts_supervisor.sv
// Purpose: supervision and fault manager: stop-mode watchdog disable, supplies, short and thermal
// Assumes: all inputs synchronous to clk_i; Wishbone classic slave, one wait state
// Notes: watchdog timing itself lives elsewhere; this block starts or stops it
// What this block does
// RL1: arm watchdog-off only in normal, both bits
// RL2: sequence error clears second arm bit
// RL3: stop trigger or normal return restarts watchdog
// RL4: restarting sequence with first bit set clears it
// RL5: bus-wake restart option defaults one, normal-only
// RL6: bus wake in stop restarts watchdog, irq, rxd
// RL7: controller re-disables via normal mode and sequence
// RL8: power-on sets flag, defaults, holds reset
// RL9: battery below power-on level switches off, restarts
// RL10: battery undervoltage flag, third regulator, short suspend
// RL11: high-side undervoltage forces lin receive-only
// RL12: high-side overvoltage sets only its flag
// RL13: main prewarning sets flag only
// RL14: main undervoltage drives reset, flag, restart
// RL15: fourth consecutive undervoltage enters fail-safe
// RL16: main overvoltage flag, optional restart or fail-safe
// RL17: overvoltage restart returns normal after delay
// RL18: main not up in filter time: short
// RL19: main low beyond filter time: short
// RL20: second regulator, can supply undervoltage sticky
// RL21: stage overheat switches stage off, flag
// RL22: transceiver overheat disables transmitter only
// RL23: controller writes arm a then arm b
`timescale 1ns/10ps
module sts_supervisor
  import sts_pkg::*;
#(
  parameter int RD1_CYC = STS_RD1_CYC,
  parameter int SC_CYC = STS_SC_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire sts_supply_t supply_i,
  input wire sts_heat_t heat_i,
  input wire logic config_pin_level_i,
  input wire logic can_wake_i,
  input wire logic lin_wake_i,
  input wire logic wk_pin_wake_i,
  output sts_mode_t mode_o,
  output logic reset_output_pin_n_o,
  output logic fail_outputs_o,
  output logic main_supply_on_o,
  output logic third_reg_on_o,
  output logic [1:0] second_reg_on_bits_o,
  output logic [3:0] hs_enable_o,
  output logic lin_rx_only_o,
  output logic can_tx_off_o,
  output logic [1:0] lin_tx_off_o,
  output logic wd_active_o,
  output logic wd_long_window_o,
  output logic wake_irq_o,
  output logic can_rxd_low_o,
  output logic lin_rxd_low_o
);
  sts_mode_t mode;
  logic [2:0] wake_ctrl;
  logic [1:0] watchdog_control_reg;
  logic [5:0] out_ctrl;
  logic [STS_NFLAGS-1:0] flags;
  logic [1:0] can_fail, lin_one_failure_field, lin_two_failure_field;
  logic [STS_CNT_W-1:0] rd_cnt, sc_cnt;
  logic [2:0] uv_cnt;
  logic prev_main_ok, prev_main_ov, ro_n;

  // bus strobes: writes land on the edge that sees ack high
  logic wr, sel_lo;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign sel_lo = wb_sel_i[0];

  function automatic logic hit(input logic [7:0] off);
    hit = wr & sel_lo & (wb_adr_i == off);
  endfunction

  // decoded events
  logic pwr_off, in_active, mode_wr, soft_rst, to_normal, wd_trig, stop_trig;
  logic bus_wake, any_wake, main_fall, ov_rise, ov_act, uv_event, uv_fs, sc_hit, rd_done;
  assign pwr_off = ~supply_i.bat_above_por;
  assign in_active = (mode == mode_init) | (mode == mode_normal) | (mode == mode_stop);
  assign mode_wr = hit(STS_MODE_OFF);
  assign soft_rst = mode_wr & (wb_dat_i[1:0] == STS_CMD_SOFT_RST) & ((mode == mode_normal) | (mode == mode_stop));
  assign to_normal = mode_wr & (wb_dat_i[1:0] == STS_CMD_NORMAL) & ((mode == mode_stop) | (mode == mode_init));
  assign wd_trig = hit(STS_WATCHDOG_CONTROL_REG_OFF);
  assign stop_trig = wd_trig & (mode == mode_stop);
  assign bus_wake = (mode == mode_stop) & wake_ctrl[STS_BUS_WAKE_BIT] & ~wd_active_o & (can_wake_i | lin_wake_i);
  assign any_wake = can_wake_i | lin_wake_i | wk_pin_wake_i;
  assign main_fall = prev_main_ok & ~supply_i.main_above_rt & (mode != mode_sleep) & (mode != mode_off);
  assign ov_rise = supply_i.main_ov & ~prev_main_ov & in_active;
  assign ov_act = ov_rise & watchdog_control_reg[STS_OV_RST_BIT];
  // counter holds in normal while the battery is low
  assign uv_event = main_fall & in_active & ~((mode == mode_normal) & supply_i.bat_uv);
  assign uv_fs = uv_event & (uv_cnt == STS_UV_LIMIT - 3'h1);
  assign sc_hit = sc_cnt == STS_CNT_W'(SC_CYC - 1);
  assign rd_done = rd_cnt == STS_CNT_W'(RD1_CYC - 1);

  // previous levels for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_main_ok <= 1'b0;
      prev_main_ov <= 1'b0;
    end else begin
      prev_main_ok <= supply_i.main_above_rt;
      prev_main_ov <= supply_i.main_ov;
    end
  end

  // mode sequencing, highest priority first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= mode_off;
    end else if (pwr_off) begin
      mode <= mode_off; // [RL9]
    end else begin
      case (mode)
        mode_off: mode <= mode_init; // [RL9]
        mode_sleep: if (any_wake) mode <= mode_restart;
        mode_failsafe: if (any_wake) mode <= mode_restart; // [RL19]
        mode_restart: if (sc_hit) mode <= mode_failsafe;
          else if (rd_done) mode <= mode_normal; // [RL17]
        mode_init, mode_normal, mode_stop: begin
          if (sc_hit) begin
            mode <= mode_failsafe; // [RL18] [RL19]
          end else if (uv_fs) begin
            mode <= mode_failsafe; // [RL15]
          end else if (main_fall) begin
            mode <= mode_restart; // [RL14]
          end else if (ov_act) begin
            mode <= config_pin_level_i ? mode_restart : mode_failsafe; // [RL16] [RL17]
          end else if (soft_rst) begin
            mode <= mode_init;
          end else if (mode_wr && mode == mode_normal && wb_dat_i[1:0] == STS_CMD_STOP) begin
            mode <= mode_stop;
          end else if (mode_wr && mode == mode_normal && wb_dat_i[1:0] == STS_CMD_SLEEP) begin
            mode <= mode_sleep;
          end else if (to_normal || (mode == mode_init && wd_trig && ro_n)) begin
            mode <= mode_normal; // [RL3]
          end
        end
        default: mode <= mode_off;
      endcase
    end
  end

  // reset delay: runs while main supply is up and reset is held
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_off || soft_rst || !supply_i.main_above_rt || main_fall) begin
      rd_cnt <= '0;
      ro_n <= 1'b0; // [RL8] [RL14]
    end else if (ov_act && config_pin_level_i) begin
      rd_cnt <= '0;
      ro_n <= 1'b0; // [RL16]
    end else if (!ro_n) begin
      rd_cnt <= rd_done ? rd_cnt : rd_cnt + 1'b1;
      ro_n <= rd_done; // [RL8]
    end
  end

  // short filter: main supply low while it should be up, battery not low
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_off || supply_i.main_above_rt || supply_i.bat_uv || !main_supply_on_o) begin
      sc_cnt <= '0; // [RL10]
    end else if (mode != mode_sleep && mode != mode_failsafe && !sc_hit) begin
      sc_cnt <= sc_cnt + 1'b1; // [RL18] [RL19]
    end
  end

  // consecutive undervoltage counter
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_off || soft_rst || uv_fs || mode == mode_failsafe) begin
      uv_cnt <= '0; // [RL15]
    end else if (wr && wb_adr_i == STS_STATUS_OFF && sel_lo && wb_dat_i[STS_F_MAIN_UV] && !uv_event) begin
      uv_cnt <= '0; // [RL15]
    end else if (uv_event) begin
      uv_cnt <= uv_cnt + 3'h1;
    end
  end

  // wake control: arm a, bus-wake option, third regulator keep-on
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_off || soft_rst) begin
      wake_ctrl <= STS_WAKE_CTRL_RST; // [RL5] [RL8]
    end else if (stop_trig || to_normal || bus_wake) begin
      wake_ctrl[STS_ARM_A_BIT] <= 1'b0; // [RL3]
    end else if (hit(STS_WAKE_CTRL_OFF) && mode == mode_normal) begin
      // rewriting arm a while set restarts the sequence and drops it
      wake_ctrl[STS_ARM_A_BIT] <= wb_dat_i[STS_ARM_A_BIT] & ~wake_ctrl[STS_ARM_A_BIT]; // [RL1] [RL4]
      wake_ctrl[STS_BUS_WAKE_BIT] <= wb_dat_i[STS_BUS_WAKE_BIT]; // [RL5]
      wake_ctrl[STS_KEEP_ON_BIT] <= wb_dat_i[STS_KEEP_ON_BIT];
    end
  end

  // watchdog control: arm b, overvoltage restart option
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_off || soft_rst) begin
      watchdog_control_reg <= STS_WATCHDOG_CONTROL_REG_RST;
    end else if (stop_trig || to_normal || bus_wake) begin
      watchdog_control_reg[STS_ARM_B_BIT] <= 1'b0; // [RL3] [RL6]
    end else if (ov_act && config_pin_level_i) begin
      watchdog_control_reg[STS_OV_RST_BIT] <= 1'b0; // [RL16]
    end else if (hit(STS_WAKE_CTRL_OFF) && watchdog_control_reg[STS_ARM_B_BIT]) begin
      watchdog_control_reg[STS_ARM_B_BIT] <= 1'b0; // [RL2] [RL23]
    end else if (wd_trig && mode == mode_normal) begin
      // arm b without arm a is a sequence error
      watchdog_control_reg[STS_ARM_B_BIT] <= wb_dat_i[STS_ARM_B_BIT] & wake_ctrl[STS_ARM_A_BIT]; // [RL1] [RL2]
      watchdog_control_reg[STS_OV_RST_BIT] <= wb_dat_i[STS_OV_RST_BIT];
    end
  end

  // watchdog run state and long-window start pulse
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_off) begin
      wd_active_o <= 1'b0;
      wd_long_window_o <= 1'b0;
    end else if (stop_trig || to_normal || bus_wake) begin
      wd_active_o <= 1'b1; // [RL3] [RL6]
      wd_long_window_o <= 1'b1;
    end else if (mode == mode_normal && mode_wr && wb_dat_i[1:0] == STS_CMD_STOP) begin
      wd_active_o <= ~(wake_ctrl[STS_ARM_A_BIT] & watchdog_control_reg[STS_ARM_B_BIT]); // [RL1]
      wd_long_window_o <= 1'b0;
    end else begin
      wd_active_o <= in_active & (wd_active_o | (ro_n & (mode != mode_stop))); // [RL1]
      wd_long_window_o <= 1'b0;
    end
  end

  // bus wake signalling to the controller
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_off || mode == mode_normal) begin
      wake_irq_o <= 1'b0;
      can_rxd_low_o <= 1'b0;
      lin_rxd_low_o <= 1'b0;
    end else begin
      wake_irq_o <= bus_wake; // [RL6]
      can_rxd_low_o <= can_rxd_low_o | (bus_wake & can_wake_i); // [RL6]
      lin_rxd_low_o <= lin_rxd_low_o | (bus_wake & lin_wake_i);
    end
  end

  // sticky status flags: set wins over a write-one clear
  logic [STS_NFLAGS-1:0] set_f, clr_ok, clr_f;
  always_comb begin
    set_f = '0;
    set_f[STS_F_BAT_UV] = supply_i.bat_uv; // [RL10]
    set_f[STS_F_HS_UV] = supply_i.hs_uv; // [RL11]
    set_f[STS_F_HS_OV] = supply_i.hs_ov; // [RL12]
    set_f[STS_F_PREWARN] = supply_i.main_prewarn & (mode != mode_sleep); // [RL13]
    set_f[STS_F_MAIN_UV] = main_fall; // [RL14]
    set_f[STS_F_REP_UV] = uv_fs; // [RL15]
    set_f[STS_F_MAIN_OV] = ov_rise; // [RL16]
    set_f[STS_F_SHORT] = sc_hit; // [RL18] [RL19]
    set_f[STS_F_SEC_UV] = supply_i.second_uv & ~supply_i.second_ramping; // [RL20]
    set_f[STS_F_CAN_UV] = supply_i.can_uv; // [RL20]
    set_f[STS_F_BLOCK_OT] = (heat_i.second_reg & |out_ctrl[1:0]) | (heat_i.hs & |out_ctrl[5:2])
      | heat_i.can | heat_i.lin1 | heat_i.lin2; // [RL21]
    set_f[STS_F_SEC_OT] = heat_i.second_reg & |out_ctrl[1:0]; // [RL21]
    clr_ok = '1;
    clr_ok[STS_F_BLOCK_OT] = ~(heat_i.second_reg | heat_i.hs | heat_i.can | heat_i.lin1 | heat_i.lin2);
    clr_ok[STS_F_SEC_OT] = ~heat_i.second_reg; // [RL21]
    clr_f = '0;
    if (wr && wb_adr_i == STS_STATUS_OFF) begin
      clr_f = wb_dat_i[STS_NFLAGS-1:0] & {{5{wb_sel_i[1]}}, {8{sel_lo}}} & clr_ok;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_off) begin
      flags <= STS_STATUS_RST; // [RL8]
    end else begin
      flags <= (flags & ~clr_f) | set_f;
    end
  end

  // output stage control with thermal switch-off
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_off || soft_rst) begin
      out_ctrl <= STS_OUT_CTRL_RST;
    end else begin
      if (hit(STS_OUT_CTRL_OFF)) begin
        out_ctrl <= wb_dat_i[5:0];
      end
      if (heat_i.second_reg) begin
        out_ctrl[1:0] <= 2'h0; // [RL21]
      end
      if (heat_i.hs) begin
        out_ctrl[5:2] <= 4'h0; // [RL21]
      end
    end
  end

  // transceiver failure fields follow overtemperature
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_off) begin
      can_fail <= 2'h0;
      lin_one_failure_field <= 2'h0;
      lin_two_failure_field <= 2'h0;
    end else begin
      can_fail <= heat_i.can ? STS_FAIL_OT : 2'h0; // [RL22]
      lin_one_failure_field <= heat_i.lin1 ? STS_FAIL_OT : 2'h0;
      lin_two_failure_field <= heat_i.lin2 ? STS_FAIL_OT : 2'h0;
    end
  end

  // pin-level outputs, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i || pwr_off) begin
      mode_o <= mode_off;
      reset_output_pin_n_o <= 1'b0;
      fail_outputs_o <= 1'b0;
      main_supply_on_o <= 1'b0;
      third_reg_on_o <= 1'b0;
      second_reg_on_bits_o <= 2'h0;
      hs_enable_o <= 4'h0;
      lin_rx_only_o <= 1'b0;
      can_tx_off_o <= 1'b0;
      lin_tx_off_o <= 2'h0;
    end else begin
      mode_o <= mode;
      reset_output_pin_n_o <= ro_n;
      if (sc_hit || uv_fs || ov_act) begin
        fail_outputs_o <= 1'b1; // [RL16] [RL18]
      end else if (mode == mode_normal) begin
        fail_outputs_o <= 1'b0;
      end
      // main supply off after a short and in sleep, on again on wake
      main_supply_on_o <= ~(sc_hit | mode == mode_sleep | (mode == mode_failsafe & flags[STS_F_SHORT])); // [RL18]
      third_reg_on_o <= ~supply_i.bat_uv | wake_ctrl[STS_KEEP_ON_BIT]; // [RL10]
      second_reg_on_bits_o <= out_ctrl[1:0];
      hs_enable_o <= out_ctrl[5:2];
      lin_rx_only_o <= supply_i.hs_uv; // [RL11]
      can_tx_off_o <= heat_i.can; // [RL22]
      lin_tx_off_o <= {heat_i.lin2, heat_i.lin1};
    end
  end

  // wishbone answer: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wb_adr_i)
        STS_MODE_OFF: wb_dat_o <= {29'h0, mode};
        STS_WAKE_CTRL_OFF: wb_dat_o <= {29'h0, wake_ctrl};
        STS_WATCHDOG_CONTROL_REG_OFF: wb_dat_o <= {30'h0, watchdog_control_reg};
        STS_STATUS_OFF: wb_dat_o <= {19'h0, flags};
        STS_FAIL_OFF: wb_dat_o <= {26'h0, lin_two_failure_field, lin_one_failure_field, can_fail};
        STS_OUT_CTRL_OFF: wb_dat_o <= {26'h0, out_ctrl};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_arm_b_error: assert property (wd_trig && mode == mode_normal && wb_dat_i[0] && !wake_ctrl[0]
    && !stop_trig && !ov_act |=> !watchdog_control_reg[STS_ARM_B_BIT]) else $error("arm b kept after error"); // [RL2]
  chk_stop_trigger: assert property (stop_trig && !pwr_off |=> wd_active_o && wd_long_window_o
    && !wake_ctrl[0] && !watchdog_control_reg[0]) else $error("stop trigger missed"); // [RL3]
  chk_rearm_clears: assert property (hit(STS_WAKE_CTRL_OFF) && mode == mode_normal && wake_ctrl[0]
    && !pwr_off && !soft_rst && !to_normal |=> !wake_ctrl[0]) else $error("arm a not dropped"); // [RL4]
  chk_bus_wake: assert property (bus_wake && !pwr_off |=> wake_irq_o && wd_active_o ##1 !wake_irq_o)
    else $error("bus wake response wrong"); // [RL6]
  chk_poweroff: assert property (pwr_off |=> mode == mode_off ##1 !reset_output_pin_n_o)
    else $error("power loss not handled"); // [RL9]
  chk_third_reg: assert property (supply_i.bat_uv && !wake_ctrl[2] && !pwr_off |=> !third_reg_on_o)
    else $error("third regulator left on"); // [RL10]
  chk_main_uv: assert property (main_fall && !pwr_off && in_active && !sc_hit && !uv_fs
    |=> mode == mode_restart && flags[STS_F_MAIN_UV] ##1 !reset_output_pin_n_o)
    else $error("undervoltage response wrong"); // [RL14]
  chk_uv_count: assert property (uv_cnt < STS_UV_LIMIT) else $error("uv counter overran"); // [RL15]
  chk_ov_restart: assert property (ov_act && config_pin_level_i && !pwr_off && !sc_hit && !main_fall
    |=> mode == mode_restart && !watchdog_control_reg[1] ##1 fail_outputs_o) else $error("ov restart wrong"); // [RL16]
  chk_short: assert property (sc_hit && !pwr_off |=> flags[STS_F_SHORT] && mode == mode_failsafe
    ##1 !main_supply_on_o && fail_outputs_o) else $error("short response wrong"); // [RL18]
  chk_sec_ot: assert property (heat_i.second_reg && |out_ctrl[1:0] && !pwr_off
    |=> out_ctrl[1:0] == 2'h0 && flags[STS_F_SEC_OT]) else $error("overheat not switched off"); // [RL21]
  chk_can_ot: assert property (heat_i.can && !pwr_off |=> can_tx_off_o && can_fail == STS_FAIL_OT)
    else $error("transmitter not disabled"); // [RL22]
endmodule

// ===== test/sts_mcu_model.sv
// Purpose: controller model issuing classic Wishbone single cycles
// Assumes: registered ack from the supervisor
// Notes: request held until ack is sampled, then one idle cycle
`timescale 1ns/10ps
module sts_mcu_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o
);
  // idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
  end
  // one access, data taken at the ack edge
  task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    we_o <= we;
    adr_o <= adr;
    dat_o <= wd;
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    rd = dat_i;
    cyc_o <= 1'b0;
    we_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

// ===== test/test_sts_supervisor.sv
// Purpose: self-checking bench for the supply and thermal supervisor
// Assumes: reset delay 20 cycles, short filter 40 cycles
// Notes: table rows first, then hand-written fault sequences
`timescale 1ns/10ps
module test_sts_supervisor;
  import sts_pkg::*;
  typedef struct packed {
    logic [9:0] pulse;
    logic [7:0] adr;
    logic [31:0] exp;
  } sts_row_t;
  localparam logic [9:0] BASE = 10'h220;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, we, ack, rst_n, fail_o, can_txo, irq, can_rxl, wd_on, main_on, lin_ro, third_on;
  logic cfg = 1'b0;
  logic can_wk = 1'b0;
  logic seen_irq = 1'b0;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, rd;
  sts_supply_t sup = sts_supply_t'(BASE);
  sts_heat_t heat = 5'h00;
  sts_mode_t mode;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  sts_row_t rows[15];

  always #5 clk_i = ~clk_i;

  sts_supervisor #(.RD1_CYC(20), .SC_CYC(40)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .supply_i(sup), .heat_i(heat),
    .config_pin_level_i(cfg), .can_wake_i(can_wk), .lin_wake_i(1'b0), .wk_pin_wake_i(1'b0),
    .mode_o(mode), .reset_output_pin_n_o(rst_n), .fail_outputs_o(fail_o), .main_supply_on_o(main_on),
    .third_reg_on_o(third_on), .second_reg_on_bits_o(), .hs_enable_o(), .lin_rx_only_o(lin_ro),
    .can_tx_off_o(can_txo),
    .lin_tx_off_o(), .wd_active_o(wd_on), .wd_long_window_o(), .wake_irq_o(irq), .can_rxd_low_o(can_rxl),
    .lin_rxd_low_o());

  sts_mcu_model mcu (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we), .adr_o(adr),
    .dat_o(wdat));

  // wake pulse catcher and hang guard
  always @(posedge clk_i) begin
    if (irq === 1'b1) seen_irq <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    mcu.access(1'b0, a, 32'h0, rd);
    check(rd, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    mcu.access(1'b1, a, d, rd);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rows = '{'{10'h000, STS_STATUS_OFF, 32'h1}, '{10'h000, STS_WAKE_CTRL_OFF, 32'h2},
      '{10'h000, STS_WATCHDOG_CONTROL_REG_OFF, 32'h0}, '{10'h000, STS_FAIL_OFF, 32'h0}, '{10'h000, STS_OUT_CTRL_OFF, 32'h0},
      '{10'h000, 8'h18, 32'h0}, '{10'h000, STS_MODE_OFF, 32'h0}, '{10'h100, STS_STATUS_OFF, 32'h2},
      '{10'h080, STS_STATUS_OFF, 32'h4}, '{10'h040, STS_STATUS_OFF, 32'h8}, '{10'h010, STS_STATUS_OFF, 32'h10},
      '{10'h008, STS_STATUS_OFF, 32'h80}, '{10'h004, STS_STATUS_OFF, 32'h200},
      '{10'h006, STS_STATUS_OFF, 32'h0}, '{10'h001, STS_STATUS_OFF, 32'h400}};
    wait_cyc(16);
    rst_i <= 1'b0;
    wait_cyc(5);
    check(32'(rst_n), 32'h0);
    wait_cyc(30);
    check(32'(rst_n), 32'h1);
    $display("test reset done");
    foreach (rows[i]) begin
      sup <= sts_supply_t'(BASE | rows[i].pulse);
      wait_cyc(3);
      sup <= sts_supply_t'(BASE);
      rd_chk(rows[i].adr, rows[i].exp);
      wr(STS_STATUS_OFF, 32'h1fff);
    end
    sup <= sts_supply_t'(BASE | 10'h180);
    wait_cyc(2);
    check({30'h0, lin_ro, third_on}, 32'h2);
    sup <= sts_supply_t'(BASE);
    wr(STS_STATUS_OFF, 32'h1fff);
    $display("test table done");
    wr(STS_MODE_OFF, {30'h0, STS_CMD_NORMAL});
    wait_cyc(2);
    check(32'(mode), 32'(mode_normal));
    wr(STS_WAKE_CTRL_OFF, 32'h3);
    wr(STS_WATCHDOG_CONTROL_REG_OFF, 32'h1);
    wr(STS_WAKE_CTRL_OFF, 32'h3);
    rd_chk(STS_WAKE_CTRL_OFF, 32'h2);
    rd_chk(STS_WATCHDOG_CONTROL_REG_OFF, 32'h0);
    $display("test sequence error done");
    wr(STS_WAKE_CTRL_OFF, 32'h3);
    wr(STS_WATCHDOG_CONTROL_REG_OFF, 32'h1);
    rd_chk(STS_WATCHDOG_CONTROL_REG_OFF, 32'h1);
    wr(STS_MODE_OFF, {30'h0, STS_CMD_STOP});
    wait_cyc(2);
    check(32'(wd_on), 32'h0);
    can_wk <= 1'b1;
    wait_cyc(2);
    can_wk <= 1'b0;
    wait_cyc(2);
    check({29'h0, seen_irq, can_rxl, wd_on}, 32'h7);
    wr(STS_WATCHDOG_CONTROL_REG_OFF, 32'h0);
    wr(STS_WAKE_CTRL_OFF, 32'h0);
    rd_chk(STS_WAKE_CTRL_OFF, 32'h2);
    rd_chk(STS_WATCHDOG_CONTROL_REG_OFF, 32'h0);
    wr(STS_MODE_OFF, {30'h0, STS_CMD_NORMAL});
    wait_cyc(2);
    check({30'h0, can_rxl, mode == mode_normal}, 32'h1);
    $display("test bus wake done");
    wr(STS_OUT_CTRL_OFF, 32'h3f);
    heat <= 5'h19;
    wait_cyc(3);
    check(32'(can_txo), 32'h1);
    rd_chk(STS_FAIL_OFF, 32'h1);
    rd_chk(STS_OUT_CTRL_OFF, 32'h0);
    wr(STS_STATUS_OFF, 32'h1fff);
    heat <= 5'h00;
    wait_cyc(3);
    check(32'(can_txo), 32'h0);
    rd_chk(STS_STATUS_OFF, 32'h1800);
    wr(STS_STATUS_OFF, 32'h1fff);
    $display("test overheat done");
    for (int k = 1; k <= 4; k++) begin
      sup <= sts_supply_t'(10'h200);
      wait_cyc(4);
      check(32'(rst_n), 32'h0);
      sup <= sts_supply_t'(BASE);
      wait_cyc(30);
      check(32'(mode), 32'((k < 4) ? mode_normal : mode_failsafe));
    end
    check(32'(fail_o), 32'h1);
    rd_chk(STS_STATUS_OFF, 32'h60);
    wr(STS_STATUS_OFF, 32'h1fff);
    can_wk <= 1'b1;
    wait_cyc(2);
    can_wk <= 1'b0;
    wait_cyc(30);
    check({30'h0, fail_o, mode == mode_normal}, 32'h1);
    $display("test repeated undervoltage done");
    wr(STS_WATCHDOG_CONTROL_REG_OFF, 32'h3);
    cfg <= 1'b1;
    sup <= sts_supply_t'(BASE | 10'h008);
    wait_cyc(4);
    check({30'h0, fail_o, mode == mode_restart}, 32'h3);
    wait_cyc(30);
    check(32'(mode), 32'(mode_normal));
    rd_chk(STS_WATCHDOG_CONTROL_REG_OFF, 32'h0);
    sup <= sts_supply_t'(BASE);
    wr(STS_STATUS_OFF, 32'h1fff);
    $display("test overvoltage done");
    sup <= sts_supply_t'(10'h200);
    wait_cyc(60);
    sup <= sts_supply_t'(BASE);
    check({29'h0, main_on, fail_o, mode == mode_failsafe}, 32'h3);
    rd_chk(STS_STATUS_OFF, 32'h120);
    $display("test short done");
    sup <= sts_supply_t'(10'h000);
    wait_cyc(3);
    check(32'(mode), 32'(mode_off));
    sup <= sts_supply_t'(BASE);
    wait_cyc(30);
    check({30'h0, rst_n, mode == mode_init}, 32'h3);
    rd_chk(STS_STATUS_OFF, 32'h1);
    $display("test power loss done");
    final_report();
  end
endmodule
